/* File: hdl/fcs_flash_ctrl.v */
// flash clock scaler, option/security state and key window routing
// assumes the register port, memory port and sequencer inputs share i_clock
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"

// Function
// - loaded flag set by first scaler write
// - scaler bits writable once, always readable
// - erase/program allowed only after scaler loaded
// - prescale bit selects bus clock or /8
// - divide selected clock by divisor plus one
// - timing pulse is one flash clock cycle
// - option register copied from nonvolatile byte at reset
// - backdoor disabled blocks key unlocking
// - key writes refused from debug, unsecured sources
// - matching eight ordered bytes unlock until reset
// - redirect disable bit controls vector redirection
// - only lock code 1:0 means unsecured
// - secure state blocks unsecured memory access
// - key match or blank check unsecures
// - key access routes window writes
// - blocked access: write dropped, read zero
// - compare key when key access cleared
// - early command sets access error, ignored
module fcs_flash_ctrl (
    input  wire        i_clock,            // bus clock, 20 MHz
    input  wire        i_resetn,           // synchronous reset, active low
    input  wire [2:0]  i_addr,             // register index
    input  wire [7:0]  i_wdata,            // register write data
    input  wire        i_wr,               // register write strobe
    input  wire        i_rd,               // register read strobe
    output reg  [7:0]  o_rdata,            // register read data, next cycle
    input  wire [7:0]  i_nv_option_byte,   // nonvolatile option byte
    input  wire [63:0] i_nv_backdoor_key,  // stored key, byte 0 in [7:0]
    input  wire        i_mem_wr,           // cpu write to memory map
    input  wire [15:0] i_mem_addr,         // cpu write address
    input  wire [7:0]  i_mem_wdata,        // cpu write data
    input  wire        i_mem_from_secure,  // write issued by secure firmware
    input  wire        i_mem_from_debug,   // write issued by debug commands
    input  wire        i_blank_ok,         // blank check found all erased
    input  wire        i_arr_rd,           // array read request
    input  wire        i_arr_wr,           // array write request
    input  wire        i_arr_unsec_src,    // request from unsecured source
    input  wire [7:0]  i_arr_rdata,        // array data for the read
    output reg  [7:0]  o_arr_rdata,        // filtered array read data
    output reg         o_arr_wr,           // filtered array write enable
    output reg         o_cmd_start,        // one-cycle command launch
    output reg         o_prog_enable,      // erase/program allowed
    output reg         o_fclk_tick,        // one pulse per flash clock
    output reg         o_secure,           // security engaged
    output reg         o_redirect_enable   // vector redirection active
);

    localparam [1:0] CMP_IDLE  = 2'h0;
    localparam [1:0] CMP_READ  = 2'h1;
    localparam [1:0] CMP_CHECK = 2'h2;
    localparam [1:0] CMP_DONE  = 2'h3;

    localparam integer PULSE_MIN_CYC = `FCS_PULSE_MIN_CYC;
    localparam integer PULSE_MAX_CYC = `FCS_PULSE_MAX_CYC;

    // window decode, shared by command launch and key capture
    function in_key_window;
        input [15:0] addr;
        begin
            in_key_window = (addr[15:3] == `FCS_KEY_WINDOW_TAG);
        end
    endfunction

    reg        scaler_loaded_flag;
    reg        prescale_by_eight;
    reg [5:0]  scaler_value_field;
    reg        backdoor_enable;
    reg        vector_redirect_disable;
    reg [1:0]  lock_state_code;
    reg        key_access_enable;
    reg        access_error_flag;
    reg [3:0]  key_count;
    reg        key_bad;
    reg [1:0]  cmp_state;
    reg [2:0]  cmp_idx;
    reg        cmp_bad;
    reg [2:0]  pre_cnt;
    reg [5:0]  div_cnt;
    reg [7:0]  next_rdata;

    wire [7:0] ram_rdata;

    // register port decode
    wire wr_scaler = i_wr && (i_addr == `FCS_REG_SCALER);
    wire wr_config = i_wr && (i_addr == `FCS_REG_CONFIG);
    wire wr_status = i_wr && (i_addr == `FCS_REG_STATUS);

    // security decode works on the live code so gating has no lag
    wire secure_now = (lock_state_code != `FCS_LOCK_UNSECURED);

    // memory window routing
    wire win_wr     = i_mem_wr && in_key_window(i_mem_addr);
    wire cmd_req    = win_wr && !key_access_enable;
    wire key_wr_req = win_wr && key_access_enable;
    wire key_wr_ok  = key_wr_req && i_mem_from_secure &&
                      !i_mem_from_debug && (cmp_state == CMP_IDLE);

    // clearing key access closes the session and starts the compare
    wire key_acc_clear = wr_config && key_access_enable &&
                         !i_wdata[`FCS_KEY_ACCESS_ENABLE_BIT];
    wire key_acc_open  = wr_config && !key_access_enable &&
                         i_wdata[`FCS_KEY_ACCESS_ENABLE_BIT];

    // unlock only when the whole ordered key matched and backdoor is on
    wire unlock_now = (cmp_state == CMP_DONE) && !cmp_bad &&
                      backdoor_enable;

    // flash clock period in bus cycles, for the timing status bit
    wire [9:0] div_base   = {4'h0, scaler_value_field} + 10'h001;
    wire [9:0] fclk_cycles = prescale_by_eight ? {div_base[6:0], 3'b000}
                                               : div_base;
    wire timing_ok = scaler_loaded_flag &&
                     (fclk_cycles >= PULSE_MIN_CYC) &&
                     (fclk_cycles <= PULSE_MAX_CYC);

    // prescaler stage: every cycle, or every eighth when prescaling
    wire pre_tick = prescale_by_eight ? (pre_cnt == `FCS_PRESCALE_LAST)
                                      : 1'b1;

    // scaler register: first write wins, later ones are dropped
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            scaler_loaded_flag <= 1'b0;
            prescale_by_eight  <= 1'b0;
            scaler_value_field <= `FCS_DIV_RESET;
        end else if (wr_scaler && !scaler_loaded_flag) begin
            scaler_loaded_flag <= 1'b1;
            prescale_by_eight  <= i_wdata[`FCS_PRESCALE_BIT];
            scaler_value_field <= i_wdata[`FCS_DIV_MSB:0];
        end
    end

    // option byte is caught while reset is held, then stays put
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            backdoor_enable         <= i_nv_option_byte[`FCS_BACKDOOR_BIT];
            vector_redirect_disable <= i_nv_option_byte[`FCS_REDIRECT_DIS_BIT];
        end
    end

    // lock code: loaded at reset, forced unsecured by key or blank check
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            lock_state_code <= i_nv_option_byte[`FCS_LOCK_MSB:0];
        end else if (unlock_now || i_blank_ok) begin
            lock_state_code <= `FCS_LOCK_UNSECURED;
        end
    end

    // key access enable bit
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            key_access_enable <= 1'b0;
        end else if (wr_config) begin
            key_access_enable <= i_wdata[`FCS_KEY_ACCESS_ENABLE_BIT];
        end
    end

    // access error: a new error outranks a same-cycle clear
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            access_error_flag <= 1'b0;
        end else if (cmd_req && !scaler_loaded_flag) begin
            access_error_flag <= 1'b1;
        end else if (wr_status && i_wdata[`FCS_ACCERR_BIT]) begin
            access_error_flag <= 1'b0;
        end
    end

    // command launch only once the timebase is set
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_cmd_start   <= 1'b0;
            o_prog_enable <= 1'b0;
        end else begin
            o_cmd_start   <= cmd_req && scaler_loaded_flag;
            o_prog_enable <= scaler_loaded_flag;
        end
    end

    // key session tracking: bytes must come in ascending order, exactly eight
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            key_count <= 4'h0;
            key_bad   <= 1'b0;
        end else if (key_acc_open || (cmp_state == CMP_DONE)) begin
            key_count <= 4'h0;
            key_bad   <= 1'b0;
        end else if (key_wr_ok) begin
            if ((key_count == `FCS_KEY_BYTES) ||
                ({1'b0, i_mem_addr[2:0]} != key_count)) begin
                key_bad <= 1'b1;
            end
            if (key_count != `FCS_KEY_BYTES) begin
                key_count <= key_count + 4'h1;
            end
        end
    end

    // compare walks the stored key one byte per two cycles; a single
    // read port keeps the store small at the cost of sixteen cycles
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            cmp_state <= CMP_IDLE;
            cmp_idx   <= 3'h0;
            cmp_bad   <= 1'b0;
        end else begin
            case (cmp_state)
                CMP_IDLE: begin
                    if (key_acc_clear) begin
                        cmp_idx   <= 3'h0;
                        cmp_bad   <= key_bad || (key_count != `FCS_KEY_BYTES);
                        cmp_state <= CMP_READ;
                    end
                end
                CMP_READ: begin
                    cmp_state <= CMP_CHECK;
                end
                CMP_CHECK: begin
                    if (ram_rdata != i_nv_backdoor_key[{cmp_idx, 3'b000} +: 8]) begin
                        cmp_bad <= 1'b1;
                    end
                    if (cmp_idx == `FCS_KEY_LAST_IDX) begin
                        cmp_state <= CMP_DONE;
                    end else begin
                        cmp_idx   <= cmp_idx + 3'h1;
                        cmp_state <= CMP_READ;
                    end
                end
                CMP_DONE: begin
                    cmp_state <= CMP_IDLE;
                end
                default: begin
                    cmp_state <= CMP_IDLE;
                end
            endcase
        end
    end

    // key byte store
    fcs_key_ram #(
        .WIDTH (8),
        .DEPTH (8),
        .AW    (3)
    ) u_key_ram (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_wr     (key_wr_ok),
        .i_waddr  (i_mem_addr[2:0]),
        .i_wdata  (i_mem_wdata),
        .i_raddr  (cmp_idx),
        .o_rdata  (ram_rdata)
    );

    // flash clock divider, held still until the scaler is written
    always @(posedge i_clock) begin
        if (!i_resetn || !scaler_loaded_flag) begin
            pre_cnt     <= 3'h0;
            div_cnt     <= 6'h00;
            o_fclk_tick <= 1'b0;
        end else begin
            pre_cnt <= pre_cnt + 3'h1;
            if (pre_tick && (div_cnt == 6'h00)) begin
                div_cnt     <= scaler_value_field;
                o_fclk_tick <= 1'b1;
            end else if (pre_tick) begin
                div_cnt     <= div_cnt - 6'h01;
                o_fclk_tick <= 1'b0;
            end else begin
                o_fclk_tick <= 1'b0;
            end
        end
    end

    // array gate: unsecured sources see zeros and lose writes while secure
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_arr_rdata <= 8'h00;
            o_arr_wr    <= 1'b0;
        end else begin
            if (i_arr_rd && !(secure_now && i_arr_unsec_src)) begin
                o_arr_rdata <= i_arr_rdata;
            end else begin
                o_arr_rdata <= 8'h00;
            end
            o_arr_wr <= i_arr_wr && !(secure_now && i_arr_unsec_src);
        end
    end

    // status level outputs, one cycle behind the code they follow
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_secure          <= 1'b1;
            o_redirect_enable <= 1'b0;
        end else begin
            o_secure          <= secure_now;
            o_redirect_enable <= !vector_redirect_disable;
        end
    end

    // read mux; reserved bits read as zero
    always @* begin
        next_rdata = 8'h00;
        case (i_addr)
            `FCS_REG_SCALER: begin
                next_rdata[`FCS_SCALER_LOADED_BIT] = scaler_loaded_flag;
                next_rdata[`FCS_PRESCALE_BIT]      = prescale_by_eight;
                next_rdata[`FCS_DIV_MSB:0]         = scaler_value_field;
            end
            `FCS_REG_OPTION: begin
                next_rdata[`FCS_BACKDOOR_BIT]     = backdoor_enable;
                next_rdata[`FCS_REDIRECT_DIS_BIT] = vector_redirect_disable;
                next_rdata[`FCS_LOCK_MSB:0]       = lock_state_code;
            end
            `FCS_REG_CONFIG: begin
                next_rdata[`FCS_KEY_ACCESS_ENABLE_BIT] = key_access_enable;
            end
            `FCS_REG_STATUS: begin
                next_rdata[`FCS_ACCERR_BIT]      = access_error_flag;
                next_rdata[`FCS_STAT_SECURE_BIT] = secure_now;
                next_rdata[`FCS_STAT_TIMING_BIT] = timing_ok;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= next_rdata;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

/* File: include/fcs_defines.vh */
// constants shared by the flash clock and security control block
// assumes an 8-bit register port and a 20 MHz bus clock
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// register indexes on the register port
`define FCS_REG_SCALER        3'h0
`define FCS_REG_OPTION        3'h1
`define FCS_REG_CONFIG        3'h2
`define FCS_REG_STATUS        3'h3

// clock scaler register fields
`define FCS_SCALER_LOADED_BIT 7
`define FCS_PRESCALE_BIT      6
`define FCS_DIV_MSB           5
`define FCS_DIV_RESET         6'h00

// option working register fields
`define FCS_BACKDOOR_BIT      7
`define FCS_REDIRECT_DIS_BIT  6
`define FCS_LOCK_MSB          1
`define FCS_LOCK_UNSECURED    2'h2

// configuration and status fields
`define FCS_KEY_ACCESS_ENABLE_BIT        5
`define FCS_ACCERR_BIT        4
`define FCS_STAT_SECURE_BIT   1
`define FCS_STAT_TIMING_BIT   0

// backdoor key window in the memory map
`define FCS_KEY_WINDOW_TAG    13'h1ff6
`define FCS_KEY_BYTES         4'h8
`define FCS_KEY_LAST_IDX      3'h7

// flash clock prescaler
`define FCS_PRESCALE_LAST     3'h7

// timing pulse bounds, nanoseconds, and bus clock rate in MHz
`define FCS_CLK_MHZ           20
`define FCS_PULSE_MIN_NS      5000
`define FCS_PULSE_MAX_NS      6700
`define FCS_PULSE_MIN_CYC     ((`FCS_PULSE_MIN_NS * `FCS_CLK_MHZ + 999) / 1000)
`define FCS_PULSE_MAX_CYC     ((`FCS_PULSE_MAX_NS * `FCS_CLK_MHZ) / 1000)

`endif

/* File: hdl/fcs_key_ram.v */
// small key byte store for the backdoor comparison sequence
// assumes one writer and one reader on the same clock; read data registered
`timescale 1ns/1ps
`default_nettype none

module fcs_key_ram #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             i_clock,   // bus clock
    input  wire             i_resetn,  // synchronous reset, active low
    input  wire             i_wr,      // write strobe
    input  wire [AW-1:0]    i_waddr,   // write address
    input  wire [WIDTH-1:0] i_wdata,   // write data
    input  wire [AW-1:0]    i_raddr,   // read address
    output reg  [WIDTH-1:0] o_rdata    // read data, one cycle later
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];

    // storage itself has no reset; stale bytes are caught by the write tracking
    always @(posedge i_clock) begin
        if (i_wr) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    // registered read port
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            o_rdata <= {WIDTH{1'b0}};
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end

endmodule
`default_nettype wire

/* File: test/fcs_flash_ctrl_props.sv */
// assertion checker for the flash clock and security control block
// assumes it is bound to fcs_flash_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_ctrl_props (
    input wire logic        i_clock,           // bus clock
    input wire logic        i_resetn,          // sync reset, active low
    input wire logic [2:0]  i_addr,            // register index
    input wire logic [7:0]  i_wdata,           // register write data
    input wire logic        i_wr,              // register write strobe
    input wire logic [7:0]  i_nv_option_byte,  // option byte
    input wire logic        i_mem_wr,          // memory write
    input wire logic [15:0] i_mem_addr,        // memory write address
    input wire logic        i_blank_ok,        // blank check passed
    input wire logic        i_arr_rd,          // array read
    input wire logic        i_arr_wr,          // array write
    input wire logic        i_arr_unsec_src,   // unsecured requester
    input wire logic [7:0]  i_arr_rdata,       // array data
    input wire logic [7:0]  o_arr_rdata,       // gated read data
    input wire logic        o_arr_wr,          // gated write
    input wire logic        o_cmd_start,       // command launch
    input wire logic        o_prog_enable,     // erase/program allowed
    input wire logic        o_fclk_tick,       // flash clock tick
    input wire logic        o_secure,          // security engaged
    input wire logic        o_redirect_enable  // redirection on
);
    logic [6:0] cfg;
    logic       got;
    logic [9:0] gap;
    logic [1:0] seen;
    logic [9:0] per;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // first scaler write and tick spacing; first gap skipped, prescaler phase unknown
    always @(posedge i_clock) begin
        if (!i_resetn) begin
            got  <= 1'b0;
            cfg  <= 7'h00;
            gap  <= 10'h000;
            seen <= 2'h0;
        end else begin
            if (i_wr && i_addr == 3'h0 && !got) begin
                got <= 1'b1;
                cfg <= i_wdata[6:0];
            end
            gap <= o_fclk_tick ? 10'h001 : gap + 10'h001;
            if (o_fclk_tick && seen != 2'h2) begin
                seen <= seen + 2'h1;
            end
        end
    end
    assign per = (10'(cfg[5:0]) + 10'h001) * (cfg[6] ? 10'h008 : 10'h001);

    a_prog_cause: assert property ($rose(o_prog_enable) |-> $past(i_wr && i_addr == 3'h0, 2))
        else $error("erase/program enabled without a scaler write");
    a_cmd_loaded: assert property (o_cmd_start |-> o_prog_enable)
        else $error("command launched before scaler loaded");
    a_tick_gap: assert property (o_fclk_tick && seen == 2'h2 |-> gap == per)
        else $error("flash clock period wrong");
    a_tick_loaded: assert property (o_fclk_tick |-> o_prog_enable)
        else $error("flash clock runs before scaler loaded");
    a_cmd_window: assert property (o_cmd_start |->
        $past(i_mem_wr) && $past(i_mem_addr[15:3]) == 13'h1ff6)
        else $error("command launched without window write");
    a_secure_decode: assert property ($rose(i_resetn) |=>
        o_secure == ($past(i_nv_option_byte[1:0], 2) != 2'h2))
        else $error("security state decode wrong");
    a_redirect_decode: assert property ($rose(i_resetn) |=>
        o_redirect_enable == !$past(i_nv_option_byte[6], 2))
        else $error("redirection state wrong");
    a_option_frozen: assert property ($past(i_resetn, 2) |-> $stable(o_redirect_enable))
        else $error("option changed outside reset");
    a_unlock_sticky: assert property (!o_secure |=> !o_secure)
        else $error("security re-engaged without reset");
    a_blank_unlock: assert property (i_blank_ok |-> ##2 !o_secure)
        else $error("blank check did not unsecure");
    a_block_read: assert property (i_arr_rd && i_arr_unsec_src |=>
        !o_secure || o_arr_rdata == 8'h00)
        else $error("secure read leaked data");
    a_block_write: assert property (i_arr_wr && i_arr_unsec_src |=> !o_secure || !o_arr_wr)
        else $error("secure write not blocked");
    a_pass_read: assert property (i_arr_rd && !i_arr_unsec_src |=>
        o_arr_rdata == $past(i_arr_rdata))
        else $error("allowed read data wrong");

    c_cmd: cover property (o_cmd_start);
    c_unlock: cover property ($fell(o_secure) && $past(i_resetn, 2));
    c_tick: cover property (o_fclk_tick && seen == 2'h2);
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// self-checking bench for the flash clock and security control block
// assumes fcs_flash_ctrl and its checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        i_clock;
    logic        i_resetn;
    logic [2:0]  i_addr;
    logic [7:0]  i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [7:0]  i_nv_option_byte;
    logic [63:0] i_nv_backdoor_key;
    logic        i_mem_wr;
    logic [15:0] i_mem_addr;
    logic [7:0]  i_mem_wdata;
    logic        i_mem_from_secure;
    logic        i_mem_from_debug;
    logic        i_blank_ok;
    logic        i_arr_rd;
    logic        i_arr_wr;
    logic        i_arr_unsec_src;
    logic [7:0]  i_arr_rdata;
    wire  [7:0]  o_rdata;
    wire  [7:0]  o_arr_rdata;
    wire         o_arr_wr;
    wire         o_cmd_start;
    wire         o_prog_enable;
    wire         o_fclk_tick;
    wire         o_secure;
    wire         o_redirect_enable;
    int          error_cnt;
    int          checks;

    fcs_flash_ctrl uut (.i_clock, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_nv_option_byte, .i_nv_backdoor_key, .i_mem_wr, .i_mem_addr, .i_mem_wdata,
        .i_mem_from_secure, .i_mem_from_debug, .i_blank_ok, .i_arr_rd, .i_arr_wr,
        .i_arr_unsec_src, .i_arr_rdata, .o_arr_rdata, .o_arr_wr, .o_cmd_start,
        .o_prog_enable, .o_fclk_tick, .o_secure, .o_redirect_enable);

    // 20 MHz bus clock
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // strobes dropped on the same edge that takes them, so calls never collide
    task reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
    endtask

    task reg_rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        d = o_rdata;
    endtask

    // one write into the key window; gaps between calls keep writes apart
    // src[1] unsecured firmware, src[0] debug commands
    task mem_wr(input logic [2:0] off, input logic [7:0] d, input logic [1:0] src);
        @(posedge i_clock);
        i_mem_wr <= 1'b1;
        i_mem_addr <= {13'h1ff6, off};
        i_mem_wdata <= d;
        i_mem_from_secure <= !src[1];
        i_mem_from_debug <= src[0];
        @(posedge i_clock);
        i_mem_wr <= 1'b0;
        @(negedge i_clock);
    endtask

    task do_reset(input logic [7:0] opt);
        logic [7:0] d;
        @(posedge i_clock);
        i_resetn <= 1'b0;
        i_nv_option_byte <= opt;
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        @(negedge i_clock);
        chk(o_secure, opt[1:0] != 2'h2);
        chk(o_redirect_enable, !opt[6]);
        reg_rd(3'h1, d);
        chk(d, opt & 8'hc3);
        reg_rd(3'h0, d);
        chk(d, 8'h00);
    endtask

    task wait_tick(output int n);
        n = 0;
        do begin
            @(negedge i_clock);
            n++;
        end while (o_fclk_tick !== 1'b1 && n < 1000);
    endtask

    initial begin
        logic [7:0]  d;
        logic [7:0]  s;
        logic [7:0]  opt;
        logic [63:0] key;
        logic [63:0] got;
        logic        blk;
        int          n;
        int          per;
        int          k;
        int          i;
        {i_resetn, i_addr, i_wdata, i_wr, i_rd, i_nv_option_byte, i_nv_backdoor_key} = '0;
        {i_mem_wr, i_mem_addr, i_mem_wdata, i_mem_from_secure, i_mem_from_debug} = '0;
        {i_blank_ok, i_arr_rd, i_arr_wr, i_arr_unsec_src, i_arr_rdata} = '0;
        error_cnt = 0;
        checks = 0;
        n = $urandom(32'h958add66);
        // every lock code pattern at reset
        for (k = 0; k < 4; k++) begin
            s = 8'($urandom);
            opt = {s[7:2], 2'(k)};
            do_reset(opt);
        end
        mem_wr(3'h0, 8'h5a, 2'h0);
        chk(o_cmd_start, 1'b0);
        reg_rd(3'h3, d);
        chk(d, 8'h12);
        reg_wr(3'h3, 8'h10);
        reg_rd(3'h3, d);
        chk(d, 8'h02);
        reg_wr(3'h1, ~opt);
        reg_rd(3'h1, d);
        chk(d, opt & 8'hc3);
        reg_wr(3'h5, 8'hff);
        reg_rd(3'h5, d);
        chk(d, 8'h00);
        // scaler loads once, later writes ignored
        s = {2'b01, 6'(12 + $urandom_range(3))};
        reg_wr(3'h0, s);
        reg_wr(3'h0, ~s);
        reg_rd(3'h0, d);
        chk(d, s | 8'h80);
        chk(o_prog_enable, 1'b1);
        per = (s[5:0] + 1) * (s[6] ? 8 : 1);
        wait_tick(n);
        wait_tick(n);
        wait_tick(n);
        chk(n, per);
        reg_rd(3'h3, d);
        chk(d[0], per >= 100 && per <= 134);
        for (i = 0; i < 8; i++) begin
            mem_wr(3'(i), 8'($urandom), 2'h0);
            chk(o_cmd_start, 1'b1);
        end
        // good key, debug source, backdoor off, bad byte, blank check, unsecured source
        for (k = 0; k < 6; k++) begin
            key = {$urandom, $urandom};
            i_nv_backdoor_key <= key;
            do_reset((k == 2) ? 8'h43 : 8'hc3);
            got = key;
            if (k == 4) begin
                @(posedge i_clock);
                i_blank_ok <= 1'b1;
                @(posedge i_clock);
                i_blank_ok <= 1'b0;
                repeat (2) @(negedge i_clock);
                chk(o_secure, 1'b0);
                // unprescaled divider run, no command follows
                reg_wr(3'h0, {2'b00, s[5:0]});
                wait_tick(n);
                wait_tick(n);
                chk(n, s[5:0] + 1);
            end else begin
                reg_wr(3'h2, 8'h20);
                reg_rd(3'h2, d);
                chk(d, 8'h20);
                if (k == 3) got[47:40] = ~key[47:40];
                for (i = 0; i < 8; i++) begin
                    mem_wr(3'(i), got[8*i +: 8], {k == 5, k == 1});
                    chk(o_cmd_start, 1'b0);
                end
                reg_wr(3'h2, 8'h00);
                repeat (20) @(negedge i_clock);
                case (k)
                    0: chk(o_secure, 1'b0);
                    1: chk(o_secure, 1'b1);
                    5: chk(o_secure, 1'b1);
                    2: chk(o_secure, 1'b1);
                    default: chk(o_secure, 1'b1);
                endcase
            end
            // unsecured requesters blocked only while secure
            blk = (k != 0 && k != 4 && k != 3);
            d = 8'($urandom);
            @(posedge i_clock);
            i_arr_rd <= 1'b1;
            i_arr_wr <= 1'b1;
            i_arr_unsec_src <= (k != 3);
            i_arr_rdata <= d;
            @(posedge i_clock);
            i_arr_rd <= 1'b0;
            i_arr_wr <= 1'b0;
            @(negedge i_clock);
            chk(o_arr_rdata, blk ? 8'h00 : d);
            chk(o_arr_wr, !blk);
        end
        complete_run();
    end

    // watchdog well beyond the expected several hundred cycles
    initial begin
        repeat (40000) @(posedge i_clock);
        error_cnt++;
        complete_run();
    end
endmodule

bind fcs_flash_ctrl fcs_flash_ctrl_props u_props (.i_clock, .i_resetn, .i_addr, .i_wdata,
    .i_wr, .i_nv_option_byte, .i_mem_wr, .i_mem_addr, .i_blank_ok, .i_arr_rd, .i_arr_wr,
    .i_arr_unsec_src, .i_arr_rdata, .o_arr_rdata, .o_arr_wr, .o_cmd_start, .o_prog_enable,
    .o_fclk_tick, .o_secure, .o_redirect_enable);
`default_nettype wire
